// [src/sacr_pkg.sv]
// Summary of operation
// RQ1: Power-off pin selectable as high impedance, driven low or driven high.
// RQ2: Wake pin detects rising edge, falling edge, high or low level.
// RQ3: Without shut-down use, pin is alarm output: alarm uses off level.
// RQ4: Off command drives off level; wake/ack command drives wake level.
// RQ5: Clock alarm sets alarm state; selected wake detection acknowledges it.
// RQ6: Backup reset forces wake state; main reset leaves that state alone.
// RQ7: Backup reset sets off level to drive-low and wake level to hi-Z.
// RQ8: Pin is high impedance after first power-up; no internal pull.
// RQ9: Software programs the supply's active off level at first start-up.
// RQ10: Writing 1 to core enable bit 0 starts core clock; 0 ignored.
// RQ11: Writing 1 to core disable bit 0 stops core clock; 0 ignored.
// RQ12: Core clock state bit reads enable state; main reset sets it to 1.
// RQ13: Peripheral clocks via enable, disable and state; state resets to zero.
// RQ14: Mode register clears on main reset; power mode set only by backup.
// RQ15: Wake/ack command beats off command written in the same word.
// RQ16: Selected wake pin detection ends power-down, restoring main supply.
// RQ17: Clock alarm ends power-down only while alarm wake enable is set.
// RQ18: Power state and pin drive live on slow tick, backup reset only.
// RQ19: Command writes pulse once, store nothing; write-only offsets read 0.
package sacr_pkg;

  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SLOW_HZ = 32_768;
  localparam int unsigned SLOW_DIV_CYC = CLK_HZ / SLOW_HZ;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned AW = 8;

  localparam logic [7:0] OFS_CORE_EN = 8'h00;
  localparam logic [7:0] OFS_CORE_DIS = 8'h04;
  localparam logic [7:0] OFS_CORE_ST = 8'h08;
  localparam logic [7:0] OFS_PERI_EN = 8'h10;
  localparam logic [7:0] OFS_PERI_DIS = 8'h14;
  localparam logic [7:0] OFS_PERI_ST = 8'h18;
  localparam logic [7:0] OFS_CGEN_MODE = 8'h20;
  localparam logic [7:0] OFS_PWR_CMD = 8'h28;
  localparam logic [7:0] OFS_PWR_MODE = 8'h2C;
  localparam logic [7:0] OFS_PWR_STATE = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN = 8'h34;
  localparam logic [7:0] OFS_IRQ_DIS = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h3C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] OFS_LAST = 8'h40;

  localparam int unsigned CMD_OFF_BIT = 0;
  localparam int unsigned CMD_ACK_BIT = 1;
  localparam int unsigned PMR_OFF_LSB = 0;
  localparam int unsigned PMR_WAKE_LSB = 2;
  localparam int unsigned PMR_ALWAKE_BIT = 4;
  localparam int unsigned PMR_ALOFF_BIT = 5;
  localparam int unsigned PMR_EDGE_LSB = 6;
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_ALARM = 1;
  localparam int unsigned IRQ_OFF = 2;
  localparam int unsigned IRQ_W = 3;

  localparam logic [7:0] PMR_RST = 8'h01;
  localparam logic CORE_RST = 1'h1;
  localparam logic [31:0] PERI_RST = 32'h0000_0000;
  localparam logic [31:0] CGEN_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IMR_RST = 3'h0;
  localparam logic [31:0] PERI_MASK_DEF = 32'h0007_EFFC;
  localparam logic [31:0] CGEN_MASK = 32'h3FFF_FF77;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LVL_HIZ = 2'h0, LVL_LOW = 2'h1, LVL_HIGH = 2'h2, LVL_RSVD = 2'h3
  } sacr_level_e;

  typedef enum logic [1:0] {
    EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_HIGH = 2'h2, EDGE_LOW = 2'h3
  } sacr_edge_e;

  typedef enum logic [1:0] {PWR_WAKE = 2'h1, PWR_OFF = 2'h2} sacr_pwr_e;

  typedef struct packed {
    logic [AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } sacr_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sacr_axi_rsp_s;

endpackage

// [src/sacr_top.sv]
`timescale 1ns/1ns
module sacr_top #(
  parameter int unsigned SLOW_DIV = sacr_pkg::SLOW_DIV_CYC,
  parameter logic [31:0] PERI_MASK = sacr_pkg::PERI_MASK_DEF
) (
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic BKUP_ARST_N,
  input wire sacr_pkg::sacr_axi_req_s AXI_REQ,
  output sacr_pkg::sacr_axi_rsp_s AXI_RSP,
  input wire logic WAKEUP_PIN,
  input wire logic RTC_ALARM,
  output logic POWER_OFF_PIN_LEVEL,
  output logic POWER_OFF_PIN_DRIVE,
  output logic CORE_CLK_EN,
  output logic [31:0] PERIPH_CLK_EN,
  output logic [31:0] CLK_GEN_MODE,
  output logic IRQ
);
  import sacr_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic core_en;
    logic [31:0] peri_en;
    logic [31:0] cgen;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
  } sacr_main_s;

  typedef struct packed {
    logic [7:0] pmr;
    sacr_pwr_e pwr;
    logic pend_off;
    logic pend_ack;
    logic pend_wake;
    logic pend_alarm;
    logic [DIV_W-1:0] div;
    logic [2:0] wk_sync;
    logic wk_filt;
    logic [3:0] wk_fill;
    logic pin_level;
    logic pin_drive;
  } sacr_bkup_s;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] mask;
    mask = '0;
    for (int i = 0; i < 4; i++) begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    return mask;
  endfunction

  // Returns {drive, level} for a level select code; reserved floats
  function automatic logic [1:0] pin_of(input logic [1:0] code);
    return {code == LVL_LOW || code == LVL_HIGH, code == LVL_HIGH};
  endfunction

  function automatic logic same_reg(input logic [AW-1:0] a,
                                    input logic [7:0] ofs);
    return a[AW-1:2] == ofs[AW-1:2];
  endfunction

  sacr_main_s m_r, m_nxt;
  sacr_bkup_s b_r, b_nxt;
  logic reg_wr;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic aw_fire, w_fire, ar_fire;
  logic slow_tick;
  logic wake_hit;
  logic filt_now;
  logic wk_ready;
  logic [1:0] sel_now;
  logic [IRQ_W-1:0] events;
  logic cmd_off, cmd_ack;

  assign reg_wr = m_r.aw_held && m_r.w_held && !m_r.bvalid;
  assign wr_addr = m_r.aw_addr;
  assign wr_data = m_r.w_data & strb_mask(m_r.w_strb);
  assign aw_fire = AXI_REQ.awvalid && !m_r.aw_held && !m_r.bvalid;
  assign w_fire = AXI_REQ.wvalid && !m_r.w_held && !m_r.bvalid;
  assign ar_fire = AXI_REQ.arvalid && !m_r.rvalid;
  // Command pulses last the write cycle only and are not stored
  assign cmd_off = reg_wr && same_reg(wr_addr, OFS_PWR_CMD)
                   && wr_data[CMD_OFF_BIT]; // RQ19
  assign cmd_ack = reg_wr && same_reg(wr_addr, OFS_PWR_CMD)
                   && wr_data[CMD_ACK_BIT]; // RQ19

  always_comb begin
    m_nxt = m_r;
    if (aw_fire) begin
      m_nxt.aw_held = 1'b1;
      m_nxt.aw_addr = AXI_REQ.awaddr;
    end
    if (w_fire) begin
      m_nxt.w_held = 1'b1;
      m_nxt.w_data = AXI_REQ.wdata;
      m_nxt.w_strb = AXI_REQ.wstrb;
    end
    if (m_r.bvalid && AXI_REQ.bready) begin
      m_nxt.bvalid = 1'b0;
    end
    m_nxt.irq_stat = m_r.irq_stat;
    if (reg_wr) begin
      m_nxt.aw_held = 1'b0;
      m_nxt.w_held = 1'b0;
      m_nxt.bvalid = 1'b1;
      m_nxt.bresp = (wr_addr > OFS_LAST + 8'h03) ? RESP_SLVERR : RESP_OKAY;
      if (same_reg(wr_addr, OFS_CORE_EN) && wr_data[0]) begin
        m_nxt.core_en = 1'b1; // RQ10
      end
      if (same_reg(wr_addr, OFS_CORE_DIS) && wr_data[0]) begin
        m_nxt.core_en = 1'b0; // RQ11
      end
      if (same_reg(wr_addr, OFS_PERI_EN)) begin
        m_nxt.peri_en = m_r.peri_en | (wr_data & PERI_MASK); // RQ13
      end
      if (same_reg(wr_addr, OFS_PERI_DIS)) begin
        m_nxt.peri_en = m_r.peri_en & ~wr_data; // RQ13
      end
      if (same_reg(wr_addr, OFS_CGEN_MODE)) begin
        m_nxt.cgen = (m_r.cgen & ~strb_mask(m_r.w_strb))
                   | (wr_data & CGEN_MASK);
      end
      if (same_reg(wr_addr, OFS_IRQ_EN)) begin
        m_nxt.irq_mask = m_r.irq_mask | wr_data[IRQ_W-1:0];
      end
      if (same_reg(wr_addr, OFS_IRQ_DIS)) begin
        m_nxt.irq_mask = m_r.irq_mask & ~wr_data[IRQ_W-1:0];
      end
      if (same_reg(wr_addr, OFS_IRQ_STAT)) begin
        m_nxt.irq_stat = m_r.irq_stat & ~wr_data[IRQ_W-1:0];
      end
    end
    // Set after clear, so an event in the clearing cycle survives
    m_nxt.irq_stat = m_nxt.irq_stat | events;
    if (m_r.rvalid && AXI_REQ.rready) begin
      m_nxt.rvalid = 1'b0;
    end
    if (ar_fire) begin
      m_nxt.rvalid = 1'b1;
      m_nxt.rresp = RESP_OKAY;
      m_nxt.rdata = '0; // RQ19
      if (same_reg(AXI_REQ.araddr, OFS_CORE_ST)) begin
        m_nxt.rdata = {31'h0, m_r.core_en}; // RQ12
      end else if (same_reg(AXI_REQ.araddr, OFS_PERI_ST)) begin
        m_nxt.rdata = m_r.peri_en; // RQ13
      end else if (same_reg(AXI_REQ.araddr, OFS_CGEN_MODE)) begin
        m_nxt.rdata = m_r.cgen;
      end else if (same_reg(AXI_REQ.araddr, OFS_PWR_MODE)) begin
        m_nxt.rdata = {24'h0, b_r.pmr};
      end else if (same_reg(AXI_REQ.araddr, OFS_PWR_STATE)) begin
        m_nxt.rdata = {28'h0, b_r.wk_filt, b_r.pin_level,
                       b_r.pin_drive, b_r.pwr == PWR_OFF};
      end else if (same_reg(AXI_REQ.araddr, OFS_IRQ_MASK)) begin
        m_nxt.rdata = {29'h0, m_r.irq_mask};
      end else if (same_reg(AXI_REQ.araddr, OFS_IRQ_STAT)) begin
        m_nxt.rdata = {29'h0, m_r.irq_stat};
      end else if (AXI_REQ.araddr > OFS_LAST + 8'h03) begin
        m_nxt.rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      m_r <= '0;
      m_r.core_en <= CORE_RST; // RQ12
      m_r.peri_en <= PERI_RST; // RQ13
      m_r.cgen <= CGEN_RST; // RQ14
      m_r.irq_mask <= IMR_RST;
    end else begin
      m_r <= m_nxt;
    end
  end

  // Backup side: survives main reset; power state and pin change on the slow tick
  assign slow_tick = b_r.div == '0;
  assign filt_now = (b_r.wk_sync[1] == b_r.wk_sync[2]) ? b_r.wk_sync[2]
                                                       : b_r.wk_filt;
  // Edges count only once the synchroniser holds real samples
  assign wk_ready = b_r.wk_fill[3];

  always_comb begin
    unique case (sacr_edge_e'(b_r.pmr[PMR_EDGE_LSB +: 2]))
      EDGE_RISE: wake_hit = filt_now && !b_r.wk_filt; // RQ2
      EDGE_FALL: wake_hit = !filt_now && b_r.wk_filt; // RQ2
      EDGE_HIGH: wake_hit = filt_now; // RQ2
      EDGE_LOW: wake_hit = !filt_now; // RQ2
    endcase
    // Reset filter must not turn the pin's idle level into an edge
    if (!wk_ready) begin
      wake_hit = 1'b0;
    end
  end

  always_comb begin
    b_nxt = b_r;
    b_nxt.div = slow_tick ? DIV_W'(SLOW_DIV - 1) : b_r.div - 1'b1;
    b_nxt.wk_sync = {b_r.wk_sync[1:0], WAKEUP_PIN};
    b_nxt.wk_filt = filt_now;
    b_nxt.wk_fill = {b_r.wk_fill[2:0], 1'b1};
    if (reg_wr && same_reg(wr_addr, OFS_PWR_MODE) && m_r.w_strb[0]) begin
      b_nxt.pmr = wr_data[7:0];
    end
    // Requests between ticks are held; a new one in the tick cycle wins
    b_nxt.pend_off = (b_r.pend_off && !slow_tick) || cmd_off;
    b_nxt.pend_ack = (b_r.pend_ack && !slow_tick) || cmd_ack;
    b_nxt.pend_wake = (b_r.pend_wake && !slow_tick) || wake_hit;
    b_nxt.pend_alarm = (b_r.pend_alarm && !slow_tick) || RTC_ALARM;
    if (slow_tick) begin
      if (b_r.pend_ack) begin
        b_nxt.pwr = PWR_WAKE; // RQ15
      end else if (b_r.pwr == PWR_OFF && b_r.pend_wake) begin
        b_nxt.pwr = PWR_WAKE; // RQ5 RQ16
      end else if (b_r.pwr == PWR_OFF && b_r.pend_alarm
                   && b_r.pmr[PMR_ALWAKE_BIT]) begin
        b_nxt.pwr = PWR_WAKE; // RQ17
      end else if (b_r.pend_off) begin
        b_nxt.pwr = PWR_OFF; // RQ4
      end else if (b_r.pend_alarm && b_r.pmr[PMR_ALOFF_BIT]) begin
        b_nxt.pwr = PWR_OFF; // RQ3
      end
      sel_now = (b_nxt.pwr == PWR_OFF) ? b_r.pmr[PMR_OFF_LSB +: 2]
                                       : b_r.pmr[PMR_WAKE_LSB +: 2]; // RQ3
      {b_nxt.pin_drive, b_nxt.pin_level} = pin_of(sel_now); // RQ1
    end else begin
      sel_now = LVL_HIZ;
    end
  end

  always_ff @(posedge CLOCK or negedge BKUP_ARST_N) begin
    if (!BKUP_ARST_N) begin
      b_r <= '0;
      b_r.pmr <= PMR_RST; // RQ7
      b_r.pwr <= PWR_WAKE; // RQ6
    end else begin
      b_r <= b_nxt; // RQ18
    end
  end

  assign events = {slow_tick && b_r.pwr == PWR_WAKE && b_nxt.pwr == PWR_OFF,
                   RTC_ALARM, wake_hit};

  assign AXI_RSP.awready = !m_r.aw_held && !m_r.bvalid;
  assign AXI_RSP.wready = !m_r.w_held && !m_r.bvalid;
  assign AXI_RSP.bvalid = m_r.bvalid;
  assign AXI_RSP.bresp = m_r.bresp;
  assign AXI_RSP.arready = !m_r.rvalid;
  assign AXI_RSP.rvalid = m_r.rvalid;
  assign AXI_RSP.rdata = m_r.rdata;
  assign AXI_RSP.rresp = m_r.rresp;
  assign POWER_OFF_PIN_LEVEL = b_r.pin_level;
  assign POWER_OFF_PIN_DRIVE = b_r.pin_drive; // RQ8
  assign CORE_CLK_EN = m_r.core_en;
  assign PERIPH_CLK_EN = m_r.peri_en;
  assign CLK_GEN_MODE = m_r.cgen;
  assign IRQ = |(m_r.irq_stat & m_r.irq_mask);

  sequence tick_with_ack;
    slow_tick && b_r.pend_ack && b_r.pend_off;
  endsequence

  sequence rd_wo_offset;
    ar_fire && (same_reg(AXI_REQ.araddr, OFS_PWR_CMD)
                || same_reg(AXI_REQ.araddr, OFS_CORE_EN));
  endsequence

  cmd_priority_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ15
    tick_with_ack |=> b_r.pwr == PWR_WAKE && !b_r.pend_ack)
    else $error("ack did not beat off command");

  off_command_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ4
    slow_tick && b_r.pend_off && !b_r.pend_ack && !b_r.pend_wake
    && !b_r.pend_alarm |=> b_r.pwr == PWR_OFF)
    else $error("off command ignored");

  pin_follows_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ1
    slow_tick |=> {b_r.pin_drive, b_r.pin_level} == pin_of((b_r.pwr == PWR_OFF)
      ? $past(b_r.pmr[1:0]) : $past(b_r.pmr[3:2])))
    else $error("pin drive does not match level select");

  backup_init_a: assert property (@(posedge CLOCK) // RQ7
    $rose(BKUP_ARST_N) |-> b_r.pmr == PMR_RST && b_r.pwr == PWR_WAKE
    && !b_r.pin_drive)
    else $error("backup reset state wrong");

  main_keeps_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ6
    !ARST_N ##1 !ARST_N |-> $stable(b_r.pmr) && $stable(b_r.pin_drive))
    else $error("main reset disturbed backup state");

  core_clock_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RQ10
    reg_wr && same_reg(wr_addr, OFS_CORE_EN) |=>
      CORE_CLK_EN == ($past(wr_data[0]) || $past(m_r.core_en)))
    else $error("core enable write wrong");

  core_stop_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RQ11
    reg_wr && same_reg(wr_addr, OFS_CORE_DIS) && wr_data[0] |=> !CORE_CLK_EN)
    else $error("core disable write wrong");

  periph_set_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RQ13
    reg_wr && same_reg(wr_addr, OFS_PERI_EN) |=>
      (PERIPH_CLK_EN & $past(wr_data & PERI_MASK)) == $past(wr_data & PERI_MASK))
    else $error("peripheral enable lost");

  wo_reads_zero_a: assert property (@(posedge CLOCK) disable iff (!ARST_N) // RQ19
    rd_wo_offset |=> AXI_RSP.rvalid && AXI_RSP.rdata == 32'h0000_0000)
    else $error("write-only offset read not zero");

  alarm_gate_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ17
    slow_tick && b_r.pwr == PWR_OFF && b_r.pend_alarm && !b_r.pend_wake
    && !b_r.pend_ack && !b_r.pmr[PMR_ALWAKE_BIT] |=> b_r.pwr == PWR_OFF)
    else $error("alarm woke supply while disabled");

  wake_exit_a: assert property (@(posedge CLOCK) disable iff (!BKUP_ARST_N) // RQ16
    slow_tick && b_r.pwr == PWR_OFF && b_r.pend_wake |=> b_r.pwr == PWR_WAKE)
    else $error("wake pin did not end power-down");

  sequence alarm_in_wake;
    slow_tick && b_r.pwr == PWR_WAKE && b_r.pend_alarm && !b_r.pend_ack
    && b_r.pmr[PMR_ALOFF_BIT];
  endsequence

  alarm_off_a: assert property ( // RQ3
    @(posedge CLOCK) disable iff (!BKUP_ARST_N)
    alarm_in_wake |=> b_r.pwr == PWR_OFF)
    else $error("alarm did not raise the alarm state");

  rise_latched_a: assert property ( // RQ2
    @(posedge CLOCK) disable iff (!BKUP_ARST_N)
    wk_ready && b_r.pmr[PMR_EDGE_LSB +: 2] == EDGE_RISE && filt_now
    && !b_r.wk_filt |=> b_r.pend_wake)
    else $error("rising wake edge not latched");

  backup_hiz_a: assert property ( // RQ8
    @(posedge CLOCK) $rose(BKUP_ARST_N) |=> !POWER_OFF_PIN_DRIVE)
    else $error("pin driven after backup reset");

  pmr_write_a: assert property ( // RQ14
    @(posedge CLOCK) disable iff (!BKUP_ARST_N)
    reg_wr && same_reg(wr_addr, OFS_PWR_MODE) && m_r.w_strb[0]
    |=> b_r.pmr == $past(wr_data[7:0]))
    else $error("power mode write lost");

  periph_clear_a: assert property ( // RQ13
    @(posedge CLOCK) disable iff (!ARST_N)
    reg_wr && same_reg(wr_addr, OFS_PERI_DIS)
    |=> (PERIPH_CLK_EN & $past(wr_data)) == 32'h0000_0000)
    else $error("peripheral disable lost");

  unmapped_err_a: assert property ( // RQ19
    @(posedge CLOCK) disable iff (!ARST_N)
    ar_fire && AXI_REQ.araddr > OFS_LAST + 8'h03
    |=> AXI_RSP.rresp == RESP_SLVERR && AXI_RSP.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

  irq_sticky_a: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    events != '0 |=> (m_r.irq_stat & $past(events)) == $past(events))
    else $error("event did not set its status bit");

endmodule

// [verif/sacr_supply_model.sv]
`timescale 1ns/1ns
module sacr_supply_model #(
  parameter logic OFF_ACTIVE = 1'b1
) (
  input wire logic pin_level,
  input wire logic pin_drive,
  output logic supply_on
);
  logic shut_wire;
  // Board resistor holds the inactive level; the pin has no pull of its own
  assign shut_wire = pin_drive ? pin_level : ~OFF_ACTIVE;
  // Active level that software must program at first start-up
  assign supply_on = (shut_wire !== OFF_ACTIVE);
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import sacr_pkg::*;
  localparam int unsigned SDIV = 8;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic arst_n, bkup_n, wake_pin, rtc_alarm;
  sacr_axi_req_s req;
  sacr_axi_rsp_s rsp;
  logic lvl, drv, core_en, irq, supply_on;
  logic [31:0] peri_en, cgen, rd;
  logic [1:0] rr, br;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  sacr_top #(.SLOW_DIV(SDIV), .PERI_MASK(PERI_MASK_DEF)) i_dut (
    .CLOCK(clk), .ARST_N(arst_n), .BKUP_ARST_N(bkup_n),
    .AXI_REQ(req), .AXI_RSP(rsp), .WAKEUP_PIN(wake_pin),
    .RTC_ALARM(rtc_alarm), .POWER_OFF_PIN_LEVEL(lvl),
    .POWER_OFF_PIN_DRIVE(drv), .CORE_CLK_EN(core_en),
    .PERIPH_CLK_EN(peri_en), .CLK_GEN_MODE(cgen), .IRQ(irq));

  sacr_supply_model #(.OFF_ACTIVE(1'b1)) i_supply (
    .pin_level(lvl), .pin_drive(drv), .supply_on(supply_on));

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Both channels offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw_done && rsp.awready === 1'b1) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_done && rsp.wready === 1'b1) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rdw(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
    rdw(a);
    chk(nm, rd, e);
  endtask

  // Pin state for a level code: 1 low, 2 high, 0 and 3 released
  task automatic pin(input string nm, input logic [1:0] code);
    logic d;
    d = (code == 2'h1) || (code == 2'h2);
    chk(nm, {30'h0, drv, drv & lvl}, {30'h0, d, code == 2'h2});
  endtask

  // Commands land at a slow tick; wait several tick periods
  task automatic ticks;
    repeat (5 * SDIV) @(posedge clk);
  endtask

  task automatic alarm;
    @(posedge clk) rtc_alarm <= 1'b1;
    @(posedge clk) rtc_alarm <= 1'b0;
  endtask

  initial begin
    req = '0;
    arst_n = 1'b0;
    bkup_n = 1'b0;
    wake_pin = 1'b0;
    rtc_alarm = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    bkup_n <= 1'b1;
    ticks();
    pin("pin_first", 2'h0);
    chk("supply_first", {31'h0, supply_on}, 32'h1);
    rdchk("pmr_rst", OFS_PWR_MODE, 32'h1);
    rdchk("core_rst", OFS_CORE_ST, 32'h1);
    rdchk("peri_rst", OFS_PERI_ST, 32'h0);
    rdchk("cgen_rst", OFS_CGEN_MODE, 32'h0);
    rdchk("mask_rst", OFS_IRQ_MASK, 32'h0);
    wr(OFS_CORE_DIS, 32'h0);
    chk("core_dis0", {31'h0, core_en}, 32'h1);
    chk("wr_okay", {30'h0, br}, {30'h0, RESP_OKAY});
    wr(OFS_CORE_DIS, 32'h1);
    rdchk("core_off", OFS_CORE_ST, 32'h0);
    wr(OFS_CORE_EN, 32'h0);
    chk("core_en0", {31'h0, core_en}, 32'h0);
    wr(OFS_CORE_EN, 32'h1);
    rdchk("core_on", OFS_CORE_ST, 32'h1);
    wr(OFS_PERI_EN, 32'hFFFF_FFFF);
    rdchk("peri_all", OFS_PERI_ST, PERI_MASK_DEF);
    wr(OFS_PERI_DIS, 32'h0000_000C);
    chk("peri_pin", peri_en, PERI_MASK_DEF & ~32'hC);
    rdchk("peri_wo", OFS_PERI_EN, 32'h0);
    wr(OFS_CGEN_MODE, 32'hFFFF_FFFF);
    rdchk("cgen_rw", OFS_CGEN_MODE, CGEN_MASK);
    chk("cgen_pin", cgen, CGEN_MASK);
    // Each wake detect mode paired with off level code e and wake level code 3 - e
    for (int e = 0; e < 4; e++) begin
      wake_pin <= e[0];
      ticks();
      wr(OFS_PWR_MODE, {24'h0, e[1:0], 2'h0, 2'(3 - e), e[1:0]});
      wr(OFS_PWR_CMD, 32'h1);
      ticks();
      pin("off_lvl", e[1:0]);
      wake_pin <= ~e[0];
      ticks();
      pin("wake_lvl", 2'(3 - e));
    end
    // Off drives high, wake drives low, alarm may wake, rising edge
    wr(OFS_PWR_MODE, 32'h16);
    wr(OFS_PWR_CMD, 32'h1);
    ticks();
    chk("supply_off", {31'h0, supply_on}, 32'h0);
    rdchk("state_off", OFS_PWR_STATE, 32'h7);
    rdchk("cmd_wo", OFS_PWR_CMD, 32'h0);
    alarm();
    ticks();
    pin("alarm_wake", 2'h1);
    chk("supply_back", {31'h0, supply_on}, 32'h1);
    wr(OFS_PWR_MODE, 32'h06);
    wr(OFS_PWR_CMD, 32'h1);
    ticks();
    alarm();
    ticks();
    pin("alarm_nowake", 2'h2);
    @(posedge clk) arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    ticks();
    pin("main_rst_pin", 2'h2);
    rdchk("main_rst_pmr", OFS_PWR_MODE, 32'h06);
    rdchk("main_rst_cgen", OFS_CGEN_MODE, 32'h0);
    rdchk("main_rst_core", OFS_CORE_ST, 32'h1);
    rdchk("main_rst_peri", OFS_PERI_ST, 32'h0);
    wr(OFS_PWR_CMD, 32'h3);
    ticks();
    pin("both_cmds", 2'h1);
    // Alarm output use: alarm raises, wake edge acknowledges
    wr(OFS_PWR_MODE, 32'h26);
    wake_pin <= 1'b0;
    ticks();
    alarm();
    ticks();
    pin("alarm_set", 2'h2);
    wake_pin <= 1'b1;
    ticks();
    pin("alarm_ack", 2'h1);
    wr(OFS_IRQ_EN, 32'h2);
    rdchk("mask_set", OFS_IRQ_MASK, 32'h2);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h7);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    alarm();
    ticks();
    chk("irq_again", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_DIS, 32'h2);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    rdchk("rsvd_zero", 8'h0C, 32'h0);
    rdchk("unmapped", 8'h80, 32'h0);
    chk("unmapped_resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(8'h80, 32'h0);
    chk("unmapped_wr", {30'h0, br}, {30'h0, RESP_SLVERR});
    @(posedge clk) bkup_n <= 1'b0;
    repeat (2) @(posedge clk);
    bkup_n <= 1'b1;
    ticks();
    pin("bkup_pin", 2'h0);
    rdchk("bkup_pmr", OFS_PWR_MODE, 32'h1);
    rdchk("bkup_no_edge", OFS_IRQ_STAT, 32'h6);
    close_out();
  end
endmodule
